// ===== src/timed_event_regs.svh
// offsets, field positions and counts for the timed event and converter block
// What this block does
// - timer 1 advances once per eight states
// - timer 2 counts both edges, once per eight
// - compare entry stays pending until its match
// - scheduled timer 2 clear acts within scan
// - clear pins clear timer 2 without scan
// - software timer match sets its status flag
// - interrupt tag bit also pulses timer interrupt on software timer, clear and convert events, not on pin events
// - clear or convert event sets no flag
// - status read clears bits zero to five
// - eight channels, ten-bit result, 1024 codes
// - conversion lasts 88 states, 4 sampling
// - sampling opens four states after trigger
// - input at reference gives all ones
// - start by command bit or schedule
// - command picks channel and start mode
// - command double buffered, restart aborts conversion
// - start clears the result register
// - busy may lag start up to eight
// - one compare entry checked per state
`ifndef TIMED_EVENT_REGS_SVH
`define TIMED_EVENT_REGS_SVH

// ****************************************************
// register offsets
// ****************************************************
`define OFF_CMD      8'h02
`define OFF_RES_LO   8'h02
`define OFF_RES_HI   8'h03
`define OFF_TIME_LO  8'h04
`define OFF_TIME_HI  8'h05
`define OFF_TAG      8'h06
`define OFF_STATUS   8'h0a

// ****************************************************
// field positions
// ****************************************************
`define TAG_REF_T2   6
`define TAG_IRQ      5
`define TAG_LEVEL    4
`define CMD_GO       3
`define ST_T1_OVF    5
`define ST_T2_OVF    4
`define RES_BUSY     3

// ****************************************************
// command channels and counts
// ****************************************************
`define CH_PIN_LAST  4'h5
`define CH_SW_FIRST  4'h8
`define CH_SW_LAST   4'hb
`define CH_T2_CLEAR  4'he
`define CH_ADC_START 4'hf
`define SCAN_LAST    3'h7
`define ADC_LAST     7'h57
`define SAMP_START   7'h04
`define SAMP_END     7'h07
`define SAR_FIRST    7'h08
`define SAR_TOP      4'ha
`define STATUS_CLR   6'h3f
`define WORD_ZERO    16'h0000
`define WORD_ONE     16'h0001
`define WORD_MAX     16'hffff

`endif

// ===== src/timed_event_pkg.sv
// types shared by the timed event and converter block
package timed_event_pkg;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'b01,
    ADC_RUN  = 2'b10
  } adc_phase_e;

  typedef struct packed {
    logic [2:0]        scan;
    logic [15:0]       t1;
    logic [15:0]       t2;
    logic [2:0]        t2_sync;
    logic [2:0]        clr_sync;
    logic              t2_lvl;
    logic              t2_pend;
    logic [7:0]        cam_valid;
    logic [7:0][6:0]   cam_tag;
    logic [7:0][15:0]  cam_time;
    logic [6:0]        tag_wr;
    logic [7:0]        time_lo;
    logic              hold_valid;
    logic [6:0]        hold_tag;
    logic [15:0]       hold_time;
    logic [5:0]        pins;
    logic [5:0]        status;
    logic              sw_irq;
    logic              cmd_pend;
    logic [2:0]        cmd_ch;
    logic [2:0]        act_ch;
    adc_phase_e        phase;
    logic [6:0]        cnt;
    logic [9:0]        sar;
    logic [9:0]        result;
    logic [7:0]        rdata;
  } state_s;

endpackage

// ===== src/timed_event_adc.sv
// timer-scheduled event unit and successive approximation converter control
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "timed_event_regs.svh"

module timed_event_adc
  import timed_event_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_t2_clk_pin,
  input  wire logic       i_capture_input_zero,
  input  wire logic       i_timer2_clear_pin,
  input  wire logic       i_cmp_above,
  output logic [7:0]      o_rdata,
  output logic [5:0]      o_timed_output_unit,
  output logic            o_sw_timer_irq,
  output logic [2:0]      o_analog_channel_sel,
  output logic            o_sample_en,
  output logic [9:0]      o_dac_code
);

  state_s     q;
  state_s     next_q;
  logic       wr_cmd;
  logic       rd_status;
  logic       clr_act;
  logic       t2_edge;
  logic [6:0] cur_tag;
  logic [3:0] cur_ch;
  logic       hit;
  logic       fire_sw;
  logic       fire_int;
  logic       start_now;
  logic       start_cam;
  logic       start;
  logic [3:0] bit_idx;
  logic [9:0] sar_final;
  logic [5:0] set_bits;

  // ****************************************************
  // bus decode and compare-slot view
  // ****************************************************
  assign wr_cmd    = i_wr && (i_addr == `OFF_CMD);
  assign rd_status = i_rd && (i_addr == `OFF_STATUS);
  assign cur_tag   = q.cam_tag[q.scan];
  assign cur_ch    = cur_tag[3:0];
  // one entry against its reference timer per state
  assign hit = q.cam_valid[q.scan] &&
               (q.cam_time[q.scan] ==
                (cur_tag[`TAG_REF_T2] ? q.t2 : q.t1));
  assign fire_sw  = hit && (cur_ch >= `CH_SW_FIRST) &&
                    (cur_ch <= `CH_SW_LAST);
  assign fire_int = hit && (cur_ch >= `CH_T2_CLEAR);
  // a scheduled start only runs a command that software left waiting
  assign start_cam = hit && (cur_ch == `CH_ADC_START) &&
                     q.cmd_pend;
  assign start_now = wr_cmd && i_wdata[`CMD_GO];
  assign start     = start_now || start_cam;
  // filtered levels: second and third stage must agree
  assign clr_act = q.clr_sync[1] && q.clr_sync[2];
  assign t2_edge = (q.t2_sync[1] == q.t2_sync[2]) &&
                   (q.t2_sync[2] != q.t2_lvl);
  // trial bit walks from msb down, one bit per eight states
  assign bit_idx = `SAR_TOP - q.cnt[6:3];

  // last decision folded in so the result is final at completion
  always_comb begin
    sar_final = q.sar;
    if (!i_cmp_above) begin
      sar_final[0] = 1'b0;
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_q   = q;
    set_bits = 6'h00;
    next_q.sw_irq = 1'b0;
    next_q.rdata  = 8'h00;

    // synchronisers; the pin OR sits before the first stage
    next_q.t2_sync  = {q.t2_sync[1:0], i_t2_clk_pin};
    next_q.clr_sync = {q.clr_sync[1:0],
                       i_capture_input_zero || i_timer2_clear_pin};

    next_q.scan = q.scan + 3'h1;

    // timer 1 steps only after a full scan
    if (q.scan == `SCAN_LAST) begin
      next_q.t1 = q.t1 + `WORD_ONE;
      if (q.t1 == `WORD_MAX) begin
        set_bits[`ST_T1_OVF] = 1'b1;
      end
    end

    // both input edges count, but at most one per scan
    if (t2_edge) begin
      next_q.t2_lvl = q.t2_sync[2];
    end
    if (q.scan == `SCAN_LAST && q.t2_pend) begin
      next_q.t2      = q.t2 + `WORD_ONE;
      next_q.t2_pend = t2_edge;
      if (q.t2 == `WORD_MAX) begin
        set_bits[`ST_T2_OVF] = 1'b1;
      end
    end else if (t2_edge) begin
      next_q.t2_pend = 1'b1;
    end

    // tag and split time writes; the high byte loads holding
    if (i_wr && i_addr == `OFF_TAG) begin
      next_q.tag_wr = i_wdata[6:0];
    end
    if (i_wr && i_addr == `OFF_TIME_LO) begin
      next_q.time_lo = i_wdata;
    end
    if (i_wr && i_addr == `OFF_TIME_HI) begin
      next_q.hold_valid = 1'b1;
      next_q.hold_tag   = q.tag_wr;
      next_q.hold_time  = {i_wdata, q.time_lo};
    end

    // holding moves into the scanned slot only if it is empty
    if (q.hold_valid && !q.cam_valid[q.scan]) begin
      next_q.cam_valid[q.scan] = 1'b1;
      next_q.cam_tag[q.scan]   = q.hold_tag;
      next_q.cam_time[q.scan]  = q.hold_time;
      if (!(i_wr && i_addr == `OFF_TIME_HI)) begin
        next_q.hold_valid = 1'b0;
      end
    end

    // an entry leaves the memory only on its own match
    if (hit) begin
      next_q.cam_valid[q.scan] = 1'b0;
      if (cur_ch <= `CH_PIN_LAST) begin
        next_q.pins[cur_ch[2:0]] = cur_tag[`TAG_LEVEL];
      end
      if (fire_sw) begin
        set_bits[cur_ch[1:0]] = 1'b1;
      end
      if ((fire_sw || fire_int) && cur_tag[`TAG_IRQ]) begin
        next_q.sw_irq = 1'b1;
      end
      // internal clear lands in whichever slot it sits
      if (cur_ch == `CH_T2_CLEAR) begin
        next_q.t2      = `WORD_ZERO;
        next_q.t2_pend = t2_edge;
      end
    end

    // pin clear overrides every other timer 2 update
    if (clr_act) begin
      next_q.t2      = `WORD_ZERO;
      next_q.t2_pend = 1'b0;
    end

    // status read clears the low six; a same-cycle set survives
    if (rd_status) begin
      next_q.status = set_bits;
    end else begin
      next_q.status = q.status | set_bits;
    end

    // command buffer fills while a conversion runs
    if (wr_cmd && !i_wdata[`CMD_GO]) begin
      next_q.cmd_pend = 1'b1;
      next_q.cmd_ch   = i_wdata[2:0];
    end

    // ****************************************************
    // converter sequence
    // ****************************************************
    case (q.phase)
      ADC_IDLE: begin
        next_q.cnt = 7'h00;
      end
      ADC_RUN: begin
        next_q.cnt = q.cnt + 7'h01;
        if (q.cnt >= `SAR_FIRST) begin
          if (q.cnt[2:0] == 3'h0) begin
            next_q.sar[bit_idx] = 1'b1;
          end
          // keep the trial bit only if the input is above it
          if (q.cnt[2:0] == 3'h7 && !i_cmp_above) begin
            next_q.sar[bit_idx] = 1'b0;
          end
        end
        // fixed length, result and idle in one step
        if (q.cnt == `ADC_LAST) begin
          next_q.result = sar_final;
          next_q.phase  = ADC_IDLE;
        end
      end
      default: begin
        next_q.phase = ADC_IDLE;
      end
    endcase

    // a new start throws away the running one
    if (start) begin
      next_q.phase    = ADC_RUN;
      next_q.cnt      = 7'h00;
      next_q.sar      = 10'h000;
      next_q.result   = 10'h000;
      // a command buffered in the start cycle waits for the next trigger
      next_q.cmd_pend = wr_cmd && !i_wdata[`CMD_GO];
      next_q.act_ch   = start_now ? i_wdata[2:0] : q.cmd_ch;
    end

    // read data stand for one cycle only
    if (i_rd) begin
      case (i_addr)
        `OFF_RES_LO: begin
          next_q.rdata = {q.result[1:0], 1'b0,
                          1'b0, q.phase == ADC_RUN,
                          q.act_ch};
        end
        `OFF_RES_HI: begin
          next_q.rdata = q.result[9:2];
        end
        `OFF_STATUS: begin
          next_q.rdata = {2'b00, q.status};
        end
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      // every field from a constant; the phase needs its one-hot idle
      q       <= '0;
      q.phase <= ADC_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign o_rdata              = q.rdata;
  assign o_timed_output_unit  = q.pins;
  assign o_sw_timer_irq       = q.sw_irq;
  assign o_analog_channel_sel = q.act_ch;
  assign o_dac_code           = q.sar;
  // sampling window opens four states in, lasts four
  assign o_sample_en = (q.phase == ADC_RUN) &&
                       (q.cnt >= `SAMP_START) &&
                       (q.cnt <= `SAMP_END);

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_conv_tail;
    (q.phase == ADC_RUN) ##1 (q.phase == ADC_IDLE);
  endsequence

  a_t1_scan_step: assert property (
    $changed(q.t1) |-> $past(q.scan) == `SCAN_LAST)
    else $error("timer 1 moved outside the scan end");

  a_t2_rate: assert property (
    (q.t2 == $past(q.t2) + `WORD_ONE) |->
      $past(q.scan) == `SCAN_LAST)
    else $error("timer 2 counted outside the scan end");

  a_entry_pending: assert property (
    (q.cam_valid[q.scan] && !hit) |=> q.cam_valid[$past(q.scan)])
    else $error("unmatched compare entry was dropped");

  a_sw_flag: assert property (
    (fire_sw && !rd_status) |=> q.status[$past(cur_ch[1:0])])
    else $error("software timer flag not set on match");

  a_sw_irq: assert property (
    (hit && cur_tag[`TAG_IRQ] &&
     (cur_ch inside {[`CH_SW_FIRST:`CH_SW_LAST], `CH_T2_CLEAR,
                     `CH_ADC_START})) |=> o_sw_timer_irq)
    else $error("timer interrupt missing after tagged match");

  a_no_flag: assert property (
    (fire_int && !rd_status) |=> q.status[3:0] == $past(q.status[3:0]))
    else $error("internal event touched a software flag");

  a_status_clear: assert property (
    rd_status |=> q.status == $past(set_bits))
    else $error("status read did not clear low bits");

  a_conv_len: assert property (
    (q.phase == ADC_RUN && q.cnt == `ADC_LAST && !start) |->
      s_conv_tail)
    else $error("conversion did not end after 88 states");

  a_sample_open: assert property (
    $rose(o_sample_en) |-> (q.cnt == `SAMP_START) ##3
      (o_sample_en || (q.cnt < `SAMP_START)))
    else $error("sampling window misplaced");

  a_start_clear: assert property (
    start |=> (q.result == 10'h000) && (q.phase == ADC_RUN) &&
      (q.cnt == 7'h00))
    else $error("start did not clear result or restart");

  a_busy_soon: assert property (
    start |-> ##[1:8] (q.phase == ADC_RUN))
    else $error("busy not seen within eight states");

  // ****************************************************
  // further checks
  // ****************************************************
  // a run steps one state at a time, so a start clearing the
  // count and the bound below together fix the length
  sequence s_run_step;
    (q.phase == ADC_RUN) && (q.cnt == $past(q.cnt) + 7'h01);
  endsequence

  a_run_step: assert property (
    (q.phase == ADC_RUN && q.cnt != `ADC_LAST && !start) |=>
      s_run_step)
    else $error("conversion count skipped a state");

  // the count never passes the last state of a run
  a_run_bound: assert property (
    (q.phase == ADC_RUN) |-> (q.cnt <= `ADC_LAST))
    else $error("conversion count ran past its end");

  // once busy drops the result is the code that was kept
  a_result_valid: assert property (
    $fell(q.phase == ADC_RUN) |-> (q.result == o_dac_code))
    else $error("busy dropped without a valid result");

  // the filtered clear wins over every count
  a_pin_clear: assert property (
    clr_act |=> (q.t2 == `WORD_ZERO))
    else $error("clear pin did not zero timer 2");

  // the multiplexer follows a start written directly
  a_mux_pick: assert property (
    start_now |=> (o_analog_channel_sel == $past(i_wdata[2:0])))
    else $error("converter channel not taken from the command");

  // a scheduled start with no command waiting starts no conversion
  a_cmd_need: assert property (
    (hit && cur_ch == `CH_ADC_START && !q.cmd_pend && !start_now &&
     q.phase == ADC_IDLE) |=> (q.phase == ADC_IDLE))
    else $error("scheduled start ran without a waiting command");

  // a pin entry drives its pin to the stored level
  a_pin_level: assert property (
    (hit && cur_ch <= `CH_PIN_LAST) |=>
      (o_timed_output_unit[$past(cur_ch[2:0])] ==
       $past(cur_tag[`TAG_LEVEL])))
    else $error("pin entry did not drive its level");

  // read data fall back to zero outside the answer cycle
  a_rdata_quiet: assert property (
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data shown without a read");

endmodule

// ===== verif/analog_source_model.sv
// analog input levels seen by the converter comparator
`timescale 1ns/1ps

module analog_source_model (
  input  wire logic [7:0][9:0] i_levels,
  input  wire logic [2:0]      i_channel,
  input  wire logic [9:0]      i_code,
  output logic                 o_above
);

  // ****************************************
  // comparator
  // ****************************************
  // ideal compare, so a level of 3ff stands for the reference itself
  assign o_above = (i_levels[i_channel] >= i_code);

endmodule

// ===== verif/tb.sv
// self-checking bench for the timed event and converter block
`timescale 1ns/1ps

module tb;

  logic            i_sys_clk, i_rst, i_wr, i_rd;
  logic            t2_pin, cap_zero, t2_clr, above, irq, samp;
  logic [7:0]      addr, wdata, rdata, rv, lo;
  logic [5:0]      pins;
  logic [2:0]      ch_sel;
  logic [9:0]      dac;
  logic [7:0][9:0] levels;
  int              n_mismatch, n_tests, cyc, samp_at, n_samp, irqs, base;
  logic [2:0]      row_ch  [5] = '{3'd0, 3'd3, 3'd7, 3'd4, 3'd5};
  logic [9:0]      row_exp [5] = '{10'h000, 10'h3ff, 10'h155, 10'h001,
                                   10'h200};

  timed_event_adc DUT (
    .i_sys_clk            (i_sys_clk),
    .i_rst                (i_rst),
    .i_addr               (addr),
    .i_wdata              (wdata),
    .i_wr                 (i_wr),
    .i_rd                 (i_rd),
    .i_t2_clk_pin         (t2_pin),
    .i_capture_input_zero (cap_zero),
    .i_timer2_clear_pin   (t2_clr),
    .i_cmp_above          (above),
    .o_rdata              (rdata),
    .o_timed_output_unit  (pins),
    .o_sw_timer_irq       (irq),
    .o_analog_channel_sel (ch_sel),
    .o_sample_en          (samp),
    .o_dac_code           (dac)
  );

  analog_source_model u_src (
    .i_levels  (levels),
    .i_channel (ch_sel),
    .i_code    (dac),
    .o_above   (above)
  );

  // ****************************************
  // clock and monitors
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // irq is a one-cycle pulse, so it is counted at every edge
  always @(posedge i_sys_clk) begin
    cyc <= i_rst ? 0 : cyc + 1;
    if (irq === 1'b1) irqs <= irqs + 1;
    if (samp === 1'b1) begin
      n_samp <= n_samp + 1;
      if (samp_at < 0) samp_at <= cyc;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge i_sys_clk);
    addr  <= a;
    wdata <= d;
    i_wr  <= 1'b1;
    @(posedge i_sys_clk);
    i_wr  <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // time low byte, then high byte, pairs with the last tag
  task automatic sched(input logic [7:0] tag, input logic [15:0] t);
    wr(8'h06, tag);
    wr(8'h04, t[7:0]);
    wr(8'h05, t[15:8]);
    idle(10); // holding register needs eight states to empty
  endtask

  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && irqs == 0; i++) idle(1);
    if (irqs == 0) begin
      n_mismatch++;
      $display("BAD irq wait expected 1 seen 0");
      final_report();
    end
  endtask

  function automatic logic [15:0] t1_soon();
    return 16'(cyc / 8 + 16); // timer 1 steps once per eight states
  endfunction

  task automatic finish_check(input logic [2:0] ch, input logic [9:0] e);
    idle(100);
    rd(8'h02);
    chk("busy done", rv[3], 1'b0);
    chk("channel", rv[2:0], ch);
    lo = rv;
    rd(8'h03);
    chk("result", {rv, lo[7:6]}, e);
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      t2_pin <= ~t2_pin;
      idle(16);
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {i_wr, i_rd, t2_pin, cap_zero, t2_clr, addr, wdata} = '0;
    {n_mismatch, n_tests, irqs, n_samp} = '0;
    samp_at = -1;
    levels = {10'h155, 10'h0f0, 10'h200, 10'h001,
              10'h3ff, 10'h111, 10'h2aa, 10'h000};
    i_rst = 1'b1;
    idle(4);
    #1 chk("outs in reset", {pins, irq, samp, rdata}, 16'h0000);
    chk("mux in reset", {ch_sel, dac}, 16'h0000);
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h7f);
    chk("unmapped", rv, 8'h00);
    // table of immediate conversions
    for (int r = 0; r < 5; r++) begin
      samp_at = -1;
      n_samp = 0;
      wr(8'h02, {5'b00001, row_ch[r]});
      base = cyc;
      idle(7);
      rd(8'h02);
      chk("busy", rv[3], 1'b1);
      finish_check(row_ch[r], row_exp[r]);
      chk("sample start", samp_at - base, 1 + 4);
      chk("sample len", n_samp, 4);
      chk("mux", ch_sel, row_ch[r]);
      chk("dac final", dac, row_exp[r]);
    end
    // restart in mid conversion
    wr(8'h02, 8'h0a);
    idle(5);
    rd(8'h03);
    chk("cleared", rv, 8'h00);
    idle(25);
    wr(8'h02, 8'h0e);
    idle(55);
    rd(8'h02);
    chk("busy restart", rv[3], 1'b1);
    finish_check(3'd6, 10'h0f0);
    // software timers, interrupt tag on even ones
    for (int k = 0; k < 4; k++) begin
      irqs = 0;
      sched(8'h08 + k + ((k % 2 == 0) ? 8'h20 : 8'h00), t1_soon());
      if (k % 2 == 0) wait_irq(300);
      else idle(180);
      idle(4);
      chk("sw irq", irqs, (k % 2 == 0) ? 1 : 0);
      rd(8'h0a);
      chk("sw flag", rv, 8'h01 << k);
      rd(8'h0a);
      chk("flag cleared", rv, 8'h00);
    end
    // pin event stays pending until timer 1 matches
    sched(8'h12, t1_soon());
    chk("pin early", pins[2], 1'b0);
    idle(160);
    chk("pin set", pins[2], 1'b1);
    // scheduled start with a waiting command
    irqs = 0;
    wr(8'h02, 8'h01);
    sched(8'h2f, t1_soon());
    wait_irq(300);
    chk("start irq", irqs, 1);
    rd(8'h0a);
    chk("no flag", rv, 8'h00);
    finish_check(3'd1, 10'h2aa);
    // timer 2 moved off zero, cleared by capture pin, counts both edges
    toggle(1);
    cap_zero <= 1'b1;
    idle(16);
    cap_zero <= 1'b0;
    idle(16);
    sched(8'h53, 16'h0003);
    toggle(2);
    chk("t2 two", pins[3], 1'b0);
    toggle(1);
    idle(16);
    chk("t2 three", pins[3], 1'b1);
    // clear pin, event keyed to one so it cannot be missed
    t2_clr <= 1'b1;
    idle(16);
    t2_clr <= 1'b0;
    idle(16);
    sched(8'h54, 16'h0001);
    toggle(1);
    idle(16);
    chk("t2 cleared", pins[4], 1'b1);
    // scheduled clear: irq but no flag, then the count restarts at zero
    irqs = 0;
    sched(8'h2e, t1_soon());
    wait_irq(300);
    chk("clear irq", irqs, 1);
    rd(8'h0a);
    chk("clear no flag", rv, 8'h00);
    sched(8'h55, 16'h0001);
    idle(8);
    chk("t2 zeroed", pins[5], 1'b0);
    toggle(1);
    idle(16);
    chk("t2 restarted", pins[5], 1'b1);
    // second reset drops the scheduled pins
    i_rst <= 1'b1;
    idle(3);
    #1 chk("pins reset", pins, 6'h00);
    final_report();
  end

endmodule
